// *** shared/pwr_mode_pkg.sv ***
// Purpose: Shared constants and types for the power reduction mode control
// Assumes: 32-bit register port, one system clock
// Notes:   Opcode and offset values are local choices
package pwr_mode_pkg;

  // Protected 32-bit sleep opcodes (both halves must match)
  localparam logic [31:0] IDLE_OPCODE = 32'h7A85_7A85;
  localparam logic [31:0] DEEP_OPCODE = 32'h6B94_6B94;

  // Register offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] RELOAD_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // Control register fields and reset values
  localparam int          CTRL_WDT_EN_BIT = 0;
  localparam int          CTRL_KICK_BIT   = 1;
  localparam logic        WDT_EN_RST      = 1'b0;
  localparam logic [15:0] RELOAD_RST      = 16'h0000;
  localparam logic [15:0] WDT_TOP         = 16'hFFFF;

  // Status register fields
  localparam int STAT_MODE_LSB  = 0;
  localparam int STAT_CAUSE_LSB = 4;
  localparam int STAT_BLOCK_BIT = 8;
  localparam int STAT_CNT_LSB   = 16;

  // Wake cause codes
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_IRQ  = 3'h1;
  localparam logic [2:0] CAUSE_NMI  = 3'h2;
  localparam logic [2:0] CAUSE_WDT  = 3'h3;
  localparam logic [2:0] CAUSE_HWR  = 3'h4;

  // Bus pin widths
  localparam int SEG_W = 8;
  localparam int CS_W  = 5;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_LIGHT = 2'b01,
    ST_XFER  = 2'b10,
    ST_DEEP  = 2'b11
  } pmode_t;

  typedef struct packed {
    logic             ale;
    logic             rd_n;
    logic             wr_n;
    logic             bus_request_pin_n;
    logic             clock_output_pin;
    logic             reset_output_pin;
    logic             hold_ack_pin;
    logic             bhe_n;
    logic [7:0]       p0l_out;
    logic             p0l_oe;
    logic [7:0]       p0h_out;
    logic             p0h_oe;
    logic [15:0]      p1_out;
    logic [SEG_W-1:0] p4_out;
    logic [CS_W-1:0]  cs_n;
  } bus_pins_t;

endpackage : pwr_mode_pkg

// *** logic/power_reduction_mode_control.sv ***
// Purpose: Light-sleep and deep-sleep control with watchdog and pin states
// Assumes: CPU flags completion; interrupt controller picks the winner
// Notes:   Overview and tags below
// Overview of operation
// (R1) Sleep instruction halts only the CPU after the previous one; peripherals run.
// (R2) Light sleep starts only on the exact protected 32-bit opcode.
// (R3) Any request enabled before entry wakes, whatever global enable or CPU priority.
// (R4) Serviceable CPU request takes its vector; resume after the halt instruction.
// (R5) Unserviceable CPU request leaves light sleep at once, resumes next instruction.
// (R6) Serviceable event-transfer request runs the transfer, then stays asleep.
// (R7) Unserviceable event-transfer request leaves light sleep and resumes.
// (R8) Falling non-maskable pin wakes; one prioritisation round; trap always entered.
// (R9) Level-0 request wakes but no vector fetch.
// (R10) Watchdog keeps counting in light sleep and resets on overflow.
// (R11) Deep sleep stops oscillator, CPU, peripheral and watchdog clocks; RAM kept.
// (R12) Only a low hardware reset input ends deep sleep, resetting registers.
// (R13) Deep sleep starts only on the exact protected 32-bit opcode.
// (R14) Deep sleep opcode acts only while non-maskable pin is low.
// (R15) No sleep until bus idle, nor if ready enabled but not seen low.
// (R16) Port latches hold; alternate pins follow in light, freeze in deep.
// (R17) Sleep: strobe low, read/write/request high; clock out runs light, high deep.
// (R18) Sleep: low data byte floats; high byte drives address only mux 8-bit.
// (R19) Sleep: address port drives last low address in demux, else latch.
// (R20) Sleep: segment pins drive last segment where strapped, else latch data.
// (R21) Sleep: byte-high and hold-ack keep; enabled selects: last low, others high; disabled ones latch.
// (R22) Sleep: reset output high if end-of-init executed, else low.
`timescale 1ns/100ps
`default_nettype none
module power_reduction_mode_control
  import pwr_mode_pkg::*;
#(
  parameter int IRQ_N   = 16,
  parameter int ALT_W   = 8,
  parameter int WDT_DIV = 2
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [31:0]           reg_rdata,
  // CPU core
  input  wire logic             instr_valid,
  input  wire logic [31:0]      instr_word,
  input  wire logic             prev_done,
  input  wire logic [3:0]       cpu_prio,
  input  wire logic             global_irq_enable,
  input  wire logic             end_init_done,
  output logic                  cpu_halt,
  output logic                  sleep_refused,
  output logic                  resume_next,
  output logic                  vector_fetch,
  output logic                  nmi_trap,
  // Interrupt system
  input  wire logic [IRQ_N-1:0] irq_req,
  input  wire logic [IRQ_N-1:0] irq_en,
  input  wire logic [3:0]       win_prio,
  input  wire logic             win_is_pec,
  input  wire logic             pec_done,
  output logic                  prio_round,
  output logic                  pec_start,
  // Clock and reset control
  output logic                  osc_en,
  output logic                  periph_clk_en,
  output logic                  wdt_reset,
  output logic                  sys_reset,
  // Pins from outside
  input  wire logic             nonmaskable_irq_pin,
  input  wire logic             hw_reset_input_n,
  // External bus controller
  input  wire logic             bus_idle,
  input  wire logic             ready_en,
  input  wire logic             ready_seen,
  input  wire logic             mux_mode,
  input  wire logic             bus8,
  input  wire logic             acc_strobe,
  input  wire logic [23:0]      acc_addr,
  input  wire logic [CS_W-1:0]  acc_cs_hit,
  input  wire logic [SEG_W-1:0] cfg_seg_mask,
  input  wire logic [CS_W-1:0]  cfg_cs_en,
  input  wire bus_pins_t        run_pins,
  input  wire logic [15:0]      p1_latch,
  input  wire logic [SEG_W-1:0] p4_latch,
  input  wire logic [CS_W-1:0]  cs_latch,
  input  wire logic [ALT_W-1:0] alt_in,
  // Pins out
  output bus_pins_t             pins,
  output logic [ALT_W-1:0]      alt_out
);

  pmode_t state_ff, nxt_state;
  logic nmi_s1_ff, nmi_s2_ff, nmi_s3_ff, hwr_s1_ff, hwr_s2_ff;
  logic [IRQ_N-1:0] en_snap_ff;
  logic wdt_en_ff, block_ff, cfg_taken_ff;
  logic [15:0] reload_ff, wdt_cnt_ff;
  logic [$clog2(WDT_DIV+1)-1:0] div_ff;
  logic [2:0] cause_ff;
  logic [23:0] last_addr_ff;
  logic [CS_W-1:0] last_cs_ff, cs_en_ff;
  logic [SEG_W-1:0] seg_mask_ff;
  bus_pins_t sleep_pins;

  // Sleep opcode decode and entry gating
  wire is_idle  = instr_valid && (instr_word == IDLE_OPCODE);  // R2
  wire is_deep  = instr_valid && (instr_word == DEEP_OPCODE);  // R13
  wire bus_ok   = bus_idle && !(ready_en && !ready_seen);      // R15
  wire nmi_low  = !nmi_s2_ff;
  wire in_run   = (state_ff == ST_RUN);
  wire go_light = in_run && is_idle && prev_done && bus_ok;    // R1
  wire go_deep  = in_run && is_deep && prev_done && bus_ok && nmi_low; // R14
  assign sleep_refused = in_run && prev_done && (is_idle || is_deep)
                         && !go_light && !go_deep;

  // Wake decode
  wire nmi_fall    = nmi_s3_ff && !nmi_s2_ff;
  wire wake_any    = |(irq_req & en_snap_ff);                  // R3
  wire serviceable = global_irq_enable && (win_prio > cpu_prio);
  wire pec_stay    = win_is_pec && serviceable;                // R6
  wire asleep      = !in_run;
  wire deep        = (state_ff == ST_DEEP);

  // Watchdog prescaler and counter
  wire wdt_tick = (div_ff == ($bits(div_ff))'(WDT_DIV - 1));
  wire wdt_ovf  = wdt_en_ff && !deep && wdt_tick && (wdt_cnt_ff == WDT_TOP); // R10
  wire wr_ctrl  = reg_wr && (reg_addr == CTRL_OFS);
  wire wr_rel   = reg_wr && (reg_addr == RELOAD_OFS);
  wire kick     = wr_ctrl && reg_wdata[CTRL_KICK_BIT];

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (go_deep)
          nxt_state = ST_DEEP;
        else if (go_light)
          nxt_state = ST_LIGHT;
      end
      ST_LIGHT: begin
        if (wdt_ovf || nmi_fall)                                // R8
          nxt_state = ST_RUN;
        else if (wake_any)
          nxt_state = pec_stay ? ST_XFER : ST_RUN;              // R5 R7
      end
      ST_XFER: begin
        if (wdt_ovf)
          nxt_state = ST_RUN;
        else if (pec_done)
          nxt_state = ST_LIGHT;                                 // R6
      end
      ST_DEEP: begin
        if (!hwr_s2_ff)
          nxt_state = ST_RUN;                                   // R12
      end
    endcase
  end

  wire light_wake = (state_ff == ST_LIGHT) && !wdt_ovf && (nmi_fall || (wake_any && !pec_stay));
  wire cpu_svc    = wake_any && !win_is_pec && serviceable && (win_prio != 4'h0); // R4 R9

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff      <= ST_RUN;
      cpu_halt      <= 1'b0;
      osc_en        <= 1'b1;
      periph_clk_en <= 1'b1;
      resume_next   <= 1'b0;
      vector_fetch  <= 1'b0;
      nmi_trap      <= 1'b0;
      prio_round    <= 1'b0;
      pec_start     <= 1'b0;
      wdt_reset     <= 1'b0;
      sys_reset     <= 1'b0;
      cause_ff      <= CAUSE_NONE;
    end else begin
      state_ff      <= nxt_state;
      cpu_halt      <= (nxt_state != ST_RUN);                   // R1
      osc_en        <= (nxt_state != ST_DEEP);                  // R11
      periph_clk_en <= (nxt_state != ST_DEEP);                  // R11
      resume_next   <= light_wake;                              // R4 R5
      vector_fetch  <= light_wake && !nmi_fall && cpu_svc;      // R4 R9
      nmi_trap      <= light_wake && nmi_fall;                  // R8
      prio_round    <= light_wake;                              // R8
      pec_start     <= (state_ff == ST_LIGHT) && (nxt_state == ST_XFER);
      wdt_reset     <= wdt_ovf;                                 // R10
      sys_reset     <= deep && !hwr_s2_ff;                      // R12
      if (light_wake)
        cause_ff <= nmi_fall ? CAUSE_NMI : CAUSE_IRQ;
      else if (wdt_ovf)
        cause_ff <= CAUSE_WDT;
      else if (deep && !hwr_s2_ff)
        cause_ff <= CAUSE_HWR;
    end
  end

  // Pin synchronisers; third nmi stage only for edge detection
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      nmi_s1_ff <= 1'b1;
      nmi_s2_ff <= 1'b1;
      nmi_s3_ff <= 1'b1;
      hwr_s1_ff <= 1'b1;
      hwr_s2_ff <= 1'b1;
    end else begin
      nmi_s1_ff <= nonmaskable_irq_pin;
      nmi_s2_ff <= nmi_s1_ff;
      nmi_s3_ff <= nmi_s2_ff;
      hwr_s1_ff <= hw_reset_input_n;
      hwr_s2_ff <= hwr_s1_ff;
    end
  end

  // Enable snapshot, last access, strap capture after reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      en_snap_ff   <= '0;
      last_addr_ff <= '0;
      last_cs_ff   <= '0;
      cfg_taken_ff <= 1'b0;
      seg_mask_ff  <= '0;
      cs_en_ff     <= '0;
    end else begin
      if (go_light)
        en_snap_ff <= irq_en;                                   // R3
      if (acc_strobe && in_run) begin
        last_addr_ff <= acc_addr;
        last_cs_ff   <= acc_cs_hit;
      end
      if (!cfg_taken_ff) begin
        cfg_taken_ff <= 1'b1;
        seg_mask_ff  <= cfg_seg_mask;
        cs_en_ff     <= cfg_cs_en;
      end
    end
  end

  // Watchdog and registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_ff     <= '0;
      wdt_cnt_ff <= RELOAD_RST;
      wdt_en_ff  <= WDT_EN_RST;
      reload_ff  <= RELOAD_RST;
      block_ff   <= 1'b0;
    end else begin
      if (!deep)
        div_ff <= wdt_tick ? '0 : div_ff + 1'b1;                // R11
      if (kick || wdt_ovf)
        wdt_cnt_ff <= reload_ff;
      else if (wdt_en_ff && !deep && wdt_tick)
        wdt_cnt_ff <= wdt_cnt_ff + 16'h0001;                    // R10
      if (wr_ctrl)
        wdt_en_ff <= reg_wdata[CTRL_WDT_EN_BIT];
      if (wr_rel)
        reload_ff <= reg_wdata[15:0];
      if (in_run && prev_done && (is_idle || is_deep))
        block_ff <= !bus_ok;
    end
  end

  wire [31:0] stat_word = {wdt_cnt_ff, 7'h00, block_ff, 1'b0, cause_ff, 2'h0, state_ff};
  wire [31:0] rd_mux = (reg_addr == CTRL_OFS)   ? {31'h0000_0000, wdt_en_ff} :
                       (reg_addr == RELOAD_OFS) ? {16'h0000, reload_ff} :
                       (reg_addr == STATUS_OFS) ? stat_word : 32'h0000_0000;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  // Pin states while asleep
  always_comb begin
    sleep_pins         = pins;                                  // R21
    sleep_pins.ale     = 1'b0;                                  // R17
    sleep_pins.rd_n    = 1'b1;
    sleep_pins.wr_n    = 1'b1;
    sleep_pins.bus_request_pin_n  = 1'b1;
    sleep_pins.clock_output_pin  = deep ? 1'b1 : run_pins.clock_output_pin;         // R17
    sleep_pins.reset_output_pin  = end_init_done;                         // R22
    sleep_pins.p0l_oe  = 1'b0;                                  // R18
    sleep_pins.p0h_oe  = mux_mode && bus8;                      // R18
    sleep_pins.p0h_out = last_addr_ff[15:8];
    sleep_pins.p1_out  = mux_mode ? p1_latch : last_addr_ff[15:0]; // R19
    sleep_pins.p4_out  = (last_addr_ff[16 +: SEG_W] & seg_mask_ff)
                       | (p4_latch & ~seg_mask_ff);             // R20
    sleep_pins.cs_n    = (~last_cs_ff & cs_en_ff) | (cs_latch & ~cs_en_ff); // R21
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pins    <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, bus_request_pin_n: 1'b1, clock_output_pin: 1'b1,
                   reset_output_pin: 1'b0, hold_ack_pin: 1'b1, bhe_n: 1'b1, p0l_out: 8'h00, p0l_oe: 1'b0,
                   p0h_out: 8'h00, p0h_oe: 1'b0, p1_out: 16'h0000, p4_out: '0, cs_n: '1};
      alt_out <= '0;
    end else begin
      pins    <= asleep ? sleep_pins : run_pins;
      alt_out <= deep ? alt_out : alt_in;                       // R16
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_LIGHT_RUNS: assert property (state_ff == ST_LIGHT |-> cpu_halt && periph_clk_en) // R1
    else $error("light sleep must halt only the CPU");
  AST_PROT_IDLE: assert property ((in_run && nxt_state == ST_LIGHT)
      |-> instr_word == IDLE_OPCODE && prev_done) // R2
    else $error("light sleep entered without protected opcode");
  AST_WAKE_ANY: assert property ((state_ff == ST_LIGHT && wake_any && !pec_stay && !wdt_ovf)
      |=> !cpu_halt && resume_next && prio_round) // R3
    else $error("enabled request did not wake");
  AST_VECTOR: assert property ((state_ff == ST_LIGHT && !nmi_fall && !wdt_ovf && wake_any
      && !win_is_pec && serviceable && win_prio != 4'h0) |=> vector_fetch) // R4
    else $error("serviceable request missed its vector");
  AST_NOSVC: assert property ((state_ff == ST_LIGHT && !nmi_fall && !wdt_ovf && wake_any
      && !serviceable) |=> !vector_fetch && state_ff == ST_RUN) // R5
    else $error("unserviceable request must resume without vector");
  AST_PEC_STAY: assert property ((state_ff == ST_XFER && pec_done && !wdt_ovf)
      |=> state_ff == ST_LIGHT && cpu_halt) // R6
    else $error("transfer did not return to light sleep");
  AST_PEC_EXIT: assert property ((state_ff == ST_LIGHT && !wdt_ovf && !nmi_fall && wake_any
      && win_is_pec && !serviceable) |=> !cpu_halt && !pec_start) // R7
    else $error("unserviceable transfer request must exit");
  AST_NMI_WAKE: assert property ((state_ff == ST_LIGHT && nmi_fall && !wdt_ovf)
      |=> nmi_trap && prio_round ##1 !nmi_trap) // R8
    else $error("non-maskable edge did not wake");
  AST_PRIO0: assert property (vector_fetch |-> $past(win_prio) != 4'h0) // R9
    else $error("vector fetched for level 0");
  AST_WDT_OVF: assert property (wdt_ovf |=> wdt_reset && !cpu_halt) // R10
    else $error("watchdog overflow lost");
  AST_DEEP_CLK: assert property (state_ff == ST_DEEP |-> !osc_en && !periph_clk_en
      && $stable(wdt_cnt_ff)) // R11
    else $error("clocks running in deep sleep");
  AST_DEEP_EXIT: assert property ((deep && hwr_s2_ff) |=> state_ff == ST_DEEP) // R12
    else $error("deep sleep left without hardware reset");
  AST_DEEP_RST: assert property ((deep && !hwr_s2_ff) |=> sys_reset && !cpu_halt) // R12
    else $error("hardware reset did not end deep sleep");
  AST_NMI_GATE: assert property ((in_run && nxt_state == ST_DEEP)
      |-> !nmi_s2_ff && instr_word == DEEP_OPCODE) // R13 R14
    else $error("deep sleep entered while pin high");
  AST_READY: assert property ((in_run && nxt_state != ST_RUN) |-> bus_idle
      && (!ready_en || ready_seen)) // R15
    else $error("sleep entered with bus busy");
  AST_STROBES: assert property (asleep |=> !pins.ale && pins.rd_n && pins.wr_n
      && pins.bus_request_pin_n && !pins.p0l_oe && pins.reset_output_pin == $past(end_init_done)) // R17 R18 R22
    else $error("bus pins wrong while asleep");

endmodule : power_reduction_mode_control
`default_nettype wire

// *** testbench/pwr_far_model.sv ***
// Purpose: Far-side model of the interrupt arbiter and event-transfer engine
// Assumes: one pending source at a time, its attributes set by the bench
// Notes:   Winner fields are junk when nothing pends, as a real arbiter may show
`timescale 1ns/100ps
`default_nettype none
module pwr_far_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Requests and attributes
  input  wire logic [15:0] irq_req,
  input  wire logic [3:0]  set_prio,
  input  wire logic        set_pec,
  input  wire logic        pec_start,
  // Winner and completion
  output logic [3:0]       win_prio,
  output logic             win_is_pec,
  output logic             pec_done
);
  logic [1:0] cnt_ff;
  logic [3:0] junk_ff;
  assign win_prio   = (|irq_req) ? set_prio : junk_ff;
  assign win_is_pec = (|irq_req) ? set_pec : junk_ff[0];
  assign pec_done   = (cnt_ff == 2'h1);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff  <= 2'h0;
      junk_ff <= 4'h5;
    end else begin
      junk_ff <= ~junk_ff + 4'h3;
      if (pec_start) begin
        cnt_ff <= 2'h3;
      end else if (cnt_ff != 2'h0) begin
        cnt_ff <= cnt_ff - 2'h1;
      end
    end
  end
endmodule : pwr_far_model
`default_nettype wire

// *** testbench/power_reduction_mode_control_bench.sv ***
// Purpose: Self-checking bench for the power reduction mode control
// Assumes: bench plays CPU, bus controller and pins; far model plays arbiter
// Notes:   Fixed-seed xorshift stimulus with corner-case tables
`timescale 1ns/100ps
`default_nettype none
module power_reduction_mode_control_bench;
  import pwr_mode_pkg::*;
  logic             mclk, rstn, reg_wr, reg_rd, instr_valid, prev_done, gie, eid, nmi_pin, hwr_n;
  logic             bus_idle, ready_en, ready_seen, mux_mode, bus8, acc_strobe, win_is_pec, pec_done;
  logic             set_pec, cpu_halt, sleep_refused, resume_next, vector_fetch, nmi_trap, prio_round;
  logic             pec_start, osc_en, periph_clk_en, wdt_reset, sys_reset, refd, hlt;
  logic [3:0]       cpu_prio, win_prio, set_prio;
  logic [7:0]       reg_addr, alt_in, alt_out, alt_s;
  logic [31:0]      reg_wdata, reg_rdata, instr_word, rng, rd_v, tmp;
  logic [15:0]      irq_req, irq_en, p1_latch;
  logic [23:0]      acc_addr;
  logic [CS_W-1:0]  acc_cs_hit, cs_latch, cs_en;
  logic [SEG_W-1:0] seg_mask, p4_latch;
  logic [6:0]       ev, m;
  bus_pins_t        run_pins, pins, old_rp;
  int               fails, compares, k, j;
  localparam logic [3:0] TP [6] = '{4'h5, 4'h5, 4'h2, 4'h0, 4'h5, 4'h5};
  localparam logic [3:0] TC [6] = '{4'h2, 4'h2, 4'h7, 4'h0, 4'h2, 4'h2};
  localparam logic       TG [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  localparam logic       TE [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

  power_reduction_mode_control #(.IRQ_N(16), .ALT_W(8), .WDT_DIV(2)) dut_u (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_valid(instr_valid), .instr_word(instr_word),
    .prev_done(prev_done), .cpu_prio(cpu_prio), .global_irq_enable(gie), .end_init_done(eid),
    .cpu_halt(cpu_halt), .sleep_refused(sleep_refused), .resume_next(resume_next),
    .vector_fetch(vector_fetch), .nmi_trap(nmi_trap), .irq_req(irq_req), .irq_en(irq_en),
    .win_prio(win_prio), .win_is_pec(win_is_pec), .pec_done(pec_done), .prio_round(prio_round),
    .pec_start(pec_start), .osc_en(osc_en), .periph_clk_en(periph_clk_en), .wdt_reset(wdt_reset),
    .sys_reset(sys_reset), .nonmaskable_irq_pin(nmi_pin), .hw_reset_input_n(hwr_n),
    .bus_idle(bus_idle), .ready_en(ready_en), .ready_seen(ready_seen), .mux_mode(mux_mode),
    .bus8(bus8), .acc_strobe(acc_strobe), .acc_addr(acc_addr), .acc_cs_hit(acc_cs_hit),
    .cfg_seg_mask(seg_mask), .cfg_cs_en(cs_en), .run_pins(run_pins), .p1_latch(p1_latch),
    .p4_latch(p4_latch), .cs_latch(cs_latch), .alt_in(alt_in), .pins(pins), .alt_out(alt_out));

  pwr_far_model far_u (
    .mclk(mclk), .rstn(rstn), .irq_req(irq_req), .set_prio(set_prio), .set_pec(set_pec),
    .pec_start(pec_start), .win_prio(win_prio), .win_is_pec(win_is_pec), .pec_done(pec_done));

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd

  // Wake pulses as {round, vector, resume, trap, transfer, watchdog, hw reset}
  function automatic logic [6:0] exp_ev(input logic [3:0] p, input logic g, input logic pe,
                                        input logic [3:0] cp);
    logic serv;
    serv = g && (p > cp);
    if (pe && serv) begin
      return 7'h04;
    end
    return {1'b1, serv && !pe && (p != 4'h0), 1'b1, 4'h0};
  endfunction : exp_ev

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_wr_t

  task automatic reg_rd_t(input logic [7:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    rd_v = reg_rdata;
  endtask : reg_rd_t

  task automatic bus_acc();
    tmp = rnd();
    @(posedge mclk);
    acc_strobe <= 1'b1;
    acc_addr   <= tmp[23:0];
    acc_cs_hit <= 5'h01 << (tmp[31:24] % 8'h05);
    @(posedge mclk);
    acc_strobe <= 1'b0;
  endtask : bus_acc

  task automatic enter(input logic [31:0] op);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_word  <= op;
    @(negedge mclk);
    refd = sleep_refused;
    @(posedge mclk);
    instr_valid <= 1'b0;
    instr_word  <= rnd();
    repeat (3) @(negedge mclk);
    hlt = cpu_halt;
  endtask : enter

  task automatic wait_evt(input int lim);
    ev = 7'h00;
    for (int n = 0; n < lim && ev == 7'h00; n++) begin
      @(negedge mclk);
      if (resume_next | nmi_trap | pec_start | wdt_reset | sys_reset) begin
        ev = {prio_round, vector_fetch, resume_next, nmi_trap, pec_start, wdt_reset, sys_reset};
      end
    end
  endtask : wait_evt

  task automatic pin_chk(input logic dp, input logic [7:0] ae);
    logic [7:0] p4e;
    p4e = (acc_addr[23:16] & seg_mask) | (p4_latch & ~seg_mask);
    chk(32'({pins.ale, pins.rd_n, pins.wr_n, pins.bus_request_pin_n, pins.p0l_oe, pins.hold_ack_pin, pins.bhe_n}),
        32'({4'h7, 1'b0, old_rp.hold_ack_pin, old_rp.bhe_n}));
    chk(32'(pins.reset_output_pin), 32'(eid));
    chk(32'(pins.clock_output_pin), 32'(dp | run_pins.clock_output_pin));
    chk(32'(pins.p0h_oe), 32'(mux_mode & bus8));
    if (mux_mode & bus8) begin
      chk(32'(pins.p0h_out), 32'(acc_addr[15:8]));
    end
    chk(32'(pins.p1_out), 32'(mux_mode ? p1_latch : acc_addr[15:0]));
    chk(32'(pins.p4_out), 32'(p4e));
    chk(32'(pins.cs_n), 32'((~acc_cs_hit & cs_en) | (cs_latch & ~cs_en)));
    chk(32'(alt_out), 32'(ae));
  endtask : pin_chk

  task automatic print_verdict();
    $display("Counts: compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    print_verdict();
  end

  initial begin
    rng = 32'h0001_2FA2;
    {reg_wr, reg_rd, instr_valid, acc_strobe, set_pec, ready_en, ready_seen, mux_mode, bus8} = '0;
    {prev_done, gie, nmi_pin, hwr_n, bus_idle} = 5'h1F;
    {reg_addr, reg_wdata, instr_word, cpu_prio, set_prio, irq_req, irq_en, alt_in} = '0;
    rd_v = rnd();
    {p1_latch, p4_latch, seg_mask} = rd_v;
    cs_latch = rd_v[4:0];
    cs_en = rd_v[10:6];
    eid = rd_v[5];
    acc_addr = 24'h00_0000;
    acc_cs_hit = 5'h01;
    run_pins = bus_pins_t'(55'({rnd(), rnd()}));
    rstn = 1'b0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    chk(32'({osc_en, periph_clk_en, cpu_halt}), 32'h6);
    reg_rd_t(CTRL_OFS);
    chk(32'(rd_v[CTRL_WDT_EN_BIT]), 32'(WDT_EN_RST));
    reg_rd_t(RELOAD_OFS);
    chk(32'(rd_v[15:0]), 32'(RELOAD_RST));
    reg_wr_t(8'h0C, rnd());
    reg_rd_t(8'h0C);
    chk(rd_v, 32'h0);
    tmp = rnd();
    reg_wr_t(RELOAD_OFS, {16'h0000, tmp[15:0]});
    reg_rd_t(RELOAD_OFS);
    chk(32'(rd_v[15:0]), 32'(tmp[15:0]));
    // Busy bus, ready never seen, corrupted opcode
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      bus_idle <= (i != 0);
      ready_en <= (i == 1);
      enter((i == 2) ? (IDLE_OPCODE ^ (32'h0000_0001 << (rnd() % 32))) : IDLE_OPCODE);
      chk(32'({refd, hlt}), (i == 2) ? 32'h0 : 32'h2);
    end
    for (int i = 0; i < 6; i++) begin
      k = rnd() % 16;
      j = (k + 1) % 16;
      rd_v = rnd();
      @(posedge mclk);
      irq_en     <= (rd_v[15:0] | (16'h0001 << k)) & ~(16'h0001 << j);
      {mux_mode, bus8} <= 2'(i);
      {eid, ready_en} <= rd_v[17:16];
      ready_seen <= 1'b1;
      alt_in     <= rd_v[31:24];
      gie        <= TG[i];
      cpu_prio   <= TC[i];
      set_prio   <= TP[i];
      set_pec    <= TE[i];
      bus_acc();
      enter(IDLE_OPCODE);
      chk(32'(hlt), 32'h1);
      old_rp = run_pins;
      @(posedge mclk);
      run_pins <= bus_pins_t'(55'({rnd(), rnd()}));
      irq_en   <= 16'h0000;
      alt_in   <= ~alt_in;
      irq_req  <= 16'h0001 << j;
      wait_evt(4);
      chk(32'(ev), 32'h0);
      pin_chk(1'b0, alt_in);
      chk(32'({osc_en, periph_clk_en}), 32'h3);
      @(posedge mclk);
      irq_req <= 16'h0001 << k;
      wait_evt(6);
      m = TE[i] ? 7'h3F : 7'h7F;
      chk(32'(ev & m), 32'(exp_ev(TP[i], TG[i], TE[i], TC[i]) & m));
      @(posedge mclk);
      irq_req <= 16'h0000;
      repeat (8) @(negedge mclk);
      chk(32'(cpu_halt), 32'(TE[i] & TG[i]));
      if (TE[i] & TG[i]) begin
        @(posedge mclk);
        nmi_pin <= 1'b0;
        wait_evt(10);
        chk(32'(ev & 7'h50), 32'h50);
        @(posedge mclk);
        nmi_pin <= 1'b1;
        repeat (6) @(posedge mclk);
      end
      if (i == 1) begin
        reg_rd_t(STATUS_OFS);
        chk(32'({rd_v[6:4], rd_v[1:0]}), 32'({CAUSE_IRQ, ST_RUN}));
      end
    end
    reg_wr_t(RELOAD_OFS, 32'h0000_FFE0);
    reg_wr_t(CTRL_OFS, 32'h0000_0003);
    enter(IDLE_OPCODE);
    wait_evt(300);
    chk(32'({hlt, ev[1]}), 32'h3);
    reg_rd_t(STATUS_OFS);
    chk(32'(rd_v[6:4]), 32'(CAUSE_WDT));
    reg_wr_t(CTRL_OFS, 32'h0000_0000);
    enter(DEEP_OPCODE);
    chk(32'({refd, hlt}), 32'h2);
    @(posedge mclk);
    nmi_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    enter(DEEP_OPCODE ^ 32'h0001_0000);
    chk(32'(hlt), 32'h0);
    bus_acc();
    enter(DEEP_OPCODE);
    chk(32'(hlt), 32'h1);
    old_rp = run_pins;
    alt_s = alt_out;
    @(posedge mclk);
    alt_in   <= ~alt_in;
    run_pins <= bus_pins_t'(55'({rnd(), rnd()}));
    repeat (3) @(negedge mclk);
    chk(32'({osc_en, periph_clk_en}), 32'h0);
    pin_chk(1'b1, alt_s);
    @(posedge mclk);
    hwr_n   <= 1'b0;
    nmi_pin <= 1'b1;
    wait_evt(10);
    chk(32'(ev[0]), 32'h1);
    @(posedge mclk);
    hwr_n <= 1'b1;
    repeat (2) @(negedge mclk);
    chk(32'({osc_en, periph_clk_en, cpu_halt}), 32'h6);
    print_verdict();
  end
endmodule : power_reduction_mode_control_bench
`default_nettype wire
